// ### logic/sbsp_pkg.sv
// Shared constants and types for the synchronous burst static memory port.
// Assumes a single clock domain; the bus master drives commands on that clock.
package sbsp_pkg;
	localparam int             ADDR_W     = 19;
	localparam int             LANES      = 4;
	localparam int             LANE_W     = 8;
	localparam int             BURST_W    = 2;
	localparam logic           ORDER_LIN  = 1'b0;
	localparam logic [1:0]     BEAT_FIRST = 2'h0;
	localparam logic [1:0]     BEAT_STEP  = 2'h1;
	localparam logic           SYNC_RST   = 1'b0;

	typedef enum logic [1:0] {
		SBSP_OP_IDLE,
		SBSP_OP_READ,
		SBSP_OP_WRITE
	} sbsp_op_type;
endpackage

// ### logic/sbsp_burst_counter.sv
// Burst counter for the two low address bits.
// Assumes load and step are already qualified by the caller's clock qualifier.
module sbsp_burst_counter
(
	input  wire logic                         mclk,
	input  wire logic                         rst_n,
	input  wire logic                         load,
	input  wire logic                         step,
	input  wire logic [sbsp_pkg::BURST_W-1:0] start_lo,
	input  wire logic                         burst_order,
	output logic      [sbsp_pkg::BURST_W-1:0] next_lo
);
	logic [sbsp_pkg::BURST_W-1:0] start_q;
	logic [sbsp_pkg::BURST_W-1:0] start_d;
	logic [sbsp_pkg::BURST_W-1:0] beat_q;
	logic [sbsp_pkg::BURST_W-1:0] beat_d;
	logic [sbsp_pkg::BURST_W-1:0] beat_nx;

	always_comb
	begin
		beat_nx = beat_q + sbsp_pkg::BEAT_STEP;
		// Linear adds, interleaved XORs; both wrap within four beats
		if (burst_order == sbsp_pkg::ORDER_LIN)
			next_lo = start_q + beat_nx;
		else
			next_lo = start_q ^ beat_nx;
		start_d = start_q;
		beat_d  = beat_q;
		if (load)
		begin
			start_d = start_lo;
			beat_d  = sbsp_pkg::BEAT_FIRST;
		end
		else if (step)
			beat_d = beat_nx;
	end

	always_ff @(posedge mclk)
	begin
		if (rst_n == sbsp_pkg::SYNC_RST)
		begin
			start_q <= '0;
			beat_q  <= '0;
		end
		else
		begin
			start_q <= start_d;
			beat_q  <= beat_d;
		end
	end
endmodule

// ### logic/sbsp_port.sv
// Device side of a flow-through burst static memory with common data I/O.
// Assumes the master drives all synchronous inputs on mclk; output enable and
// sleep request are asynchronous pins.
module sbsp_port
#(
	parameter int ADDR_W = sbsp_pkg::ADDR_W
)
(
	input  wire logic                                    mclk,
	input  wire logic                                    rst_n,
	input  wire logic [ADDR_W-1:0]                       address,
	input  wire logic                                    chip_select_one_n,
	input  wire logic                                    chip_select_two,
	input  wire logic                                    chip_select_three_n,
	input  wire logic                                    advance_or_load,
	input  wire logic                                    write_enable_n,
	input  wire logic [sbsp_pkg::LANES-1:0]              byte_write_select_n,
	input  wire logic                                    clock_qualify_n,
	input  wire logic                                    output_enable_n,
	input  wire logic                                    sleep_request,
	input  wire logic                                    burst_order,
	input  wire logic [sbsp_pkg::LANES*sbsp_pkg::LANE_W-1:0] data_bus_in,
	output logic      [sbsp_pkg::LANES*sbsp_pkg::LANE_W-1:0] data_bus_out,
	output logic                                         data_bus_oe,
	input  wire logic [sbsp_pkg::LANES-1:0]              parity_bus_in,
	output logic      [sbsp_pkg::LANES-1:0]              parity_bus_out,
	output logic                                         parity_bus_oe
);
	localparam int DEPTH = 2 ** ADDR_W;
	localparam int LW    = sbsp_pkg::LANE_W + 1;

	sbsp_pkg::sbsp_op_type op_q;
	sbsp_pkg::sbsp_op_type op_d;
	logic                  drive_q;
	logic                  drive_d;
	logic [ADDR_W-1:0]     hi_q;
	logic [ADDR_W-1:0]     hi_d;
	logic                  wr_pend_q;
	logic                  wr_pend_d;
	logic [ADDR_W-1:0]     wr_addr_q;
	logic [ADDR_W-1:0]     wr_addr_d;
	logic [sbsp_pkg::LANES-1:0] wr_sel_n_q;
	logic [sbsp_pkg::LANES-1:0] wr_sel_n_d;
	logic [sbsp_pkg::LANES-1:0] par_q;
	logic [sbsp_pkg::LANES-1:0] par_d;
	logic [sbsp_pkg::LANES*sbsp_pkg::LANE_W-1:0] dat_q;
	logic [sbsp_pkg::LANES*sbsp_pkg::LANE_W-1:0] dat_d;
	logic                  sleep_meta_q;
	logic                  sleep_q;
	logic                  qualified;
	logic                  selected;
	logic                  load;
	logic                  step;
	logic [ADDR_W-1:0]     addr_now;
	logic [sbsp_pkg::BURST_W-1:0] next_lo;
	logic                  commit;
	logic                  fwd;
	wire logic [sbsp_pkg::LANES*LW-1:0] rd_word;

	// Sleep is asynchronous: two flops before use, which also gives the
	// two-cycle entry and exit
	always_ff @(posedge mclk)
	begin
		if (rst_n == sbsp_pkg::SYNC_RST)
		begin
			sleep_meta_q <= 1'b0;
			sleep_q      <= 1'b0;
		end
		else
		begin
			sleep_meta_q <= sleep_request;
			sleep_q      <= sleep_meta_q;
		end
	end

	assign qualified = ~clock_qualify_n & ~sleep_q;
	assign selected  = ~chip_select_one_n & chip_select_two & ~chip_select_three_n;
	assign load      = qualified & ~advance_or_load;
	assign step      = qualified & advance_or_load;
	assign commit    = qualified & wr_pend_q;

	sbsp_burst_counter u_burst
	(
		.mclk        (mclk),
		.rst_n       (rst_n),
		.load        (load),
		.step        (step),
		.start_lo    (address[sbsp_pkg::BURST_W-1:0]),
		.burst_order (burst_order),
		.next_lo     (next_lo)
	);

	// Address of this edge: external on load, next burst beat on advance
	always_comb
	begin
		if (advance_or_load)
			addr_now = {hi_q[ADDR_W-1:sbsp_pkg::BURST_W], next_lo};
		else
			addr_now = address;
	end

	// Memory array, one generate slice per byte lane with its parity bit
	genvar g;
	generate
		for (g = 0; g < sbsp_pkg::LANES; g++)
		begin : g_lane
			logic [LW-1:0] lane_mem [DEPTH];
			logic [LW-1:0] wr_word;

			assign wr_word = {parity_bus_in[g], data_bus_in[g*sbsp_pkg::LANE_W +: sbsp_pkg::LANE_W]};

			// Forward a write landing on this edge so a following read sees it
			assign rd_word[g*LW +: LW] = (fwd && !wr_sel_n_q[g]) ? wr_word : lane_mem[addr_now];

			always_ff @(posedge mclk)
			begin
				if (commit && !wr_sel_n_q[g])
					lane_mem[wr_addr_q] <= wr_word;
			end
		end
	endgenerate

	assign fwd = commit && (wr_addr_q == addr_now);

	// Command decode
	always_comb
	begin
		op_d       = op_q;
		drive_d    = drive_q;
		hi_d       = hi_q;
		wr_pend_d  = wr_pend_q;
		wr_addr_d  = wr_addr_q;
		wr_sel_n_d = wr_sel_n_q;
		dat_d      = dat_q;
		par_d      = par_q;
		if (sleep_q)
		begin
			op_d      = sbsp_pkg::SBSP_OP_IDLE;
			drive_d   = 1'b0;
			wr_pend_d = 1'b0;
		end
		else if (qualified)
		begin
			wr_pend_d = 1'b0;
			if (load)
			begin
				hi_d = address;
				if (!selected)
					op_d = sbsp_pkg::SBSP_OP_IDLE;
				else if (write_enable_n)
					op_d = sbsp_pkg::SBSP_OP_READ;
				else
					op_d = sbsp_pkg::SBSP_OP_WRITE;
			end
			// Continuation keeps the latched operation type
			drive_d = (op_d == sbsp_pkg::SBSP_OP_READ);
			if (op_d == sbsp_pkg::SBSP_OP_READ)
			begin
				for (int i = 0; i < sbsp_pkg::LANES; i++)
				begin
					dat_d[i*sbsp_pkg::LANE_W +: sbsp_pkg::LANE_W] =
						rd_word[i*LW +: sbsp_pkg::LANE_W];
					par_d[i] = rd_word[i*LW + sbsp_pkg::LANE_W];
				end
			end
			if (op_d == sbsp_pkg::SBSP_OP_WRITE)
			begin
				// All lanes high: abort, nothing stored later
				wr_pend_d  = ~&byte_write_select_n;
				wr_addr_d  = addr_now;
				wr_sel_n_d = byte_write_select_n;
			end
		end
	end

	always_ff @(posedge mclk)
	begin
		if (rst_n == sbsp_pkg::SYNC_RST)
		begin
			op_q       <= sbsp_pkg::SBSP_OP_IDLE;
			drive_q    <= 1'b0;
			hi_q       <= '0;
			wr_pend_q  <= 1'b0;
			wr_addr_q  <= '0;
			wr_sel_n_q <= '1;
			dat_q      <= '0;
			par_q      <= '0;
		end
		else
		begin
			op_q       <= op_d;
			drive_q    <= drive_d;
			hi_q       <= hi_d;
			wr_pend_q  <= wr_pend_d;
			wr_addr_q  <= wr_addr_d;
			wr_sel_n_q <= wr_sel_n_d;
			dat_q      <= dat_d;
			par_q      <= par_d;
		end
	end

	// Output enable gates the registered drive without the clock
	assign data_bus_out   = dat_q;
	assign parity_bus_out = par_q;
	assign data_bus_oe    = drive_q & ~output_enable_n & ~sleep_q;
	assign parity_bus_oe  = drive_q & ~output_enable_n & ~sleep_q;
endmodule

// ### testbench/sbsp_port_monitor.sv
// Pin-level checker for the burst memory port.
// Assumes it is bound into every sbsp_port instance.
module sbsp_port_monitor
(
	input wire logic        mclk,
	input wire logic        rst_n,
	input wire logic        chip_select_one_n,
	input wire logic        chip_select_two,
	input wire logic        chip_select_three_n,
	input wire logic        advance_or_load,
	input wire logic        write_enable_n,
	input wire logic        clock_qualify_n,
	input wire logic        output_enable_n,
	input wire logic        sleep_request,
	input wire logic [31:0] data_bus_out,
	input wire logic        data_bus_oe,
	input wire logic [3:0]  parity_bus_out,
	input wire logic        parity_bus_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	wire logic ld = !clock_qualify_n && !advance_or_load;
	wire logic sel = !chip_select_one_n && chip_select_two && !chip_select_three_n;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	a_deselect_float: assert property (ld && !sel |=> !data_bus_oe)
		else $error("drive after deselect");
	a_write_float: assert property (ld && sel && !write_enable_n |=> !data_bus_oe)
		else $error("drive after write");
	a_read_drive: assert property ((!sleep_request [*3] ##0 (ld && sel && write_enable_n)
		##1 !output_enable_n) |-> data_bus_oe) else $error("read not driven");
	a_oe_masked: assert property (output_enable_n |-> !data_bus_oe)
		else $error("drive with oe high");
	a_parity_pair: assert property (parity_bus_oe == data_bus_oe)
		else $error("parity enable differs");
	a_stall_keep: assert property (clock_qualify_n |=> $stable(data_bus_out)
		&& $stable(parity_bus_out)) else $error("stall changed data");
	a_stall_oe: assert property ((!sleep_request [*3] ##0 (clock_qualify_n
		&& !output_enable_n) ##1 !output_enable_n) |-> $stable(data_bus_oe)) else $error("stall oe");
	a_sleep_float: assert property (sleep_request [*2] |=> !data_bus_oe)
		else $error("drive in sleep");
	a_reset_float: assert property (disable iff (1'b0) !rst_n |=> !data_bus_oe)
		else $error("drive after reset");
	c_read: cover property (ld && sel && write_enable_n);
	c_write: cover property (ld && sel && !write_enable_n);
	c_stall: cover property (clock_qualify_n);
endmodule
bind sbsp_port sbsp_port_monitor u_sbsp_port_monitor (.*);

// ### testbench/sbsp_bus_wire.sv
// Shared data and parity wire between the port and the bus master.
// Assumes the master enable is high only while it presents write data.
module sbsp_bus_wire
(
	input  wire logic        dev_oe,
	input  wire logic [35:0] dev_word,
	input  wire logic        mst_oe,
	input  wire logic [35:0] mst_word,
	output logic      [35:0] bus_word
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [35:0] last = 36'h0;
	always @(dev_oe, dev_word, mst_oe, mst_word)
		if (dev_oe)
			last = dev_word;
		else if (mst_oe)
			last = mst_word;
	// Released wire shows the inverse of its last level
	assign bus_word = dev_oe ? dev_word : mst_oe ? mst_word : ~last;
endmodule

// ### testbench/tb_sync_burst_sram_port.sv
// Self-checking bench for the burst memory port.
// Assumes the port, its checker and the bus wire model are compiled first.
`define CHK(a, e) \
	begin checked++; if ((a) !== (e)) begin err_total++; \
	$display("wrong value at %0t: %h vs %h", $time, a, e); end end
module tb_sync_burst_sram_port;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk = 1'b0, rst_n = 1'b0, chip_select_one_n = 1'b1, chip_select_two = 1'b1;
	logic        chip_select_three_n = 1'b0, advance_or_load = 1'b0, write_enable_n = 1'b1;
	logic        clock_qualify_n = 1'b0, output_enable_n = 1'b0, sleep_request = 1'b0;
	logic        burst_order = 1'b0, mst_oe = 1'b0, data_bus_oe, parity_bus_oe;
	logic [3:0]  byte_write_select_n = 4'hF, parity_bus_out;
	logic [5:0]  address = 6'h00;
	logic [31:0] data_bus_out;
	logic [35:0] mst_word = 36'h0, bus_word, exp_mem [0:63];
	wire logic [31:0] data_bus_in = bus_word[31:0];
	wire logic [3:0]  parity_bus_in = bus_word[35:32];
	int          err_total = 0, checked = 0;
	sbsp_port #(.ADDR_W(6)) u_sbsp_port (.*);
	sbsp_bus_wire u_sbsp_bus_wire (.dev_oe(data_bus_oe), .dev_word({parity_bus_out, data_bus_out}),
		.mst_oe(mst_oe), .mst_word(mst_word), .bus_word(bus_word));
	always #4 mclk = ~mclk;
	function automatic logic [35:0] pat(input logic [5:0] a, input logic f);
		return {a[3:0], 26'h2A5B3C1, a} ^ {36{f}};
	endfunction
	function automatic logic [5:0] nx(input logic [5:0] a, input int k);
		return burst_order ? {a[5:2], a[1:0] ^ 2'(k)} : {a[5:2], a[1:0] + 2'(k)};
	endfunction
	function automatic logic [35:0] merge(input logic [35:0] o, w, input logic [3:0] bw);
		for (int j = 0; j < 36; j++)
			if (!bw[j < 32 ? j / 8 : j - 32])
				o[j] = w[j];
		return o;
	endfunction
	task automatic step(input logic adv, wen, sel, input logic [3:0] bw, input logic [5:0] a);
		advance_or_load = adv;
		write_enable_n = wen;
		chip_select_one_n = !sel;
		byte_write_select_n = bw;
		address = a;
		@(negedge mclk);
	endtask
	task automatic t_write(input logic [5:0] a, input logic ord, f);
		logic [3:0] bw, pbw;
		burst_order = ord;
		for (int k = 0; k < 5; k++)
		begin
			if (k > 0)
				exp_mem[nx(a, k - 1)] = merge(exp_mem[nx(a, k - 1)], pat(nx(a, k - 1), f), pbw);
			mst_oe = k > 0;
			mst_word = pat(nx(a, k - 1), f);
			bw = f ? (k == 2 ? 4'hF : ~(4'h1 << k)) : 4'h0;
			if (k < 4)
				step(k != 0, 1'b0, 1'b1, bw, a);
			else
				step(1'b0, 1'b1, 1'b0, 4'hF, a);
			pbw = bw;
			`CHK(data_bus_oe, 1'b0)
		end
		mst_oe = 1'b0;
	endtask
	task automatic t_read(input logic [5:0] a, input logic ord, oen);
		burst_order = ord;
		output_enable_n = oen;
		for (int k = 0; k < 4; k++)
		begin
			step(k != 0, 1'b1, 1'b1, 4'hF, a);
			`CHK(data_bus_oe, !oen)
			if (!oen) `CHK(bus_word, exp_mem[nx(a, k)])
			if (k == 1)
			begin
				clock_qualify_n = 1'b1;
				step(1'b0, 1'b1, 1'b0, 4'hF, a);
				clock_qualify_n = 1'b0;
				`CHK(data_bus_oe, !oen)
				if (!oen) `CHK(bus_word, exp_mem[nx(a, 1)])
			end
		end
		step(1'b0, 1'b1, 1'b0, 4'hF, a);
		`CHK(data_bus_oe, 1'b0)
		output_enable_n = 1'b0;
	endtask
	task automatic t_b2b(input logic [5:0] a);
		for (int n = 0; n < 2; n++)
		begin
			step(1'b0, 1'b0, 1'b1, n ? 4'h0 : 4'hF, a);
			`CHK(data_bus_oe, 1'b0)
			mst_oe = 1'b1;
			mst_word = pat(a, n[0]) ^ 36'h5;
			if (n)
				exp_mem[a] = mst_word;
			step(1'b0, 1'b1, 1'b1, 4'hF, a);
			`CHK(bus_word, exp_mem[a])
			mst_oe = 1'b0;
		end
	endtask
	task automatic t_desel(input logic [5:0] a);
		for (int n = 0; n < 2; n++)
		begin
			step(1'b0, 1'b1, 1'b1, 4'hF, a);
			`CHK(data_bus_oe, 1'b1)
			chip_select_two = n[0];
			chip_select_three_n = n[0];
			step(1'b0, 1'b1, 1'b1, 4'hF, a);
			`CHK(data_bus_oe, 1'b0)
			chip_select_two = 1'b1;
			chip_select_three_n = 1'b0;
		end
	endtask
	task automatic t_sleep(input logic [5:0] a);
		sleep_request = 1'b1;
		repeat (3) step(1'b0, 1'b1, 1'b1, 4'hF, a);
		`CHK(data_bus_oe, 1'b0)
		sleep_request = 1'b0;
		repeat (3) step(1'b0, 1'b1, 1'b0, 4'hF, a);
		t_read(a, 1'b0, 1'b0);
	endtask
	task automatic give_verdict;
		if (err_total == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial
	begin
		#5us;
		err_total++;
		give_verdict;
	end
	initial
	begin
		repeat (8) @(negedge mclk);
		`CHK(data_bus_oe, 1'b0)
		rst_n = 1'b1;
		t_write(6'h08, 1'b0, 1'b0);
		t_write(6'h0A, 1'b1, 1'b1);
		t_read(6'h09, 1'b0, 1'b0);
		t_read(6'h0B, 1'b1, 1'b0);
		t_read(6'h0A, 1'b1, 1'b1);
		t_b2b(6'h09);
		t_desel(6'h0A);
		t_sleep(6'h0B);
		give_verdict;
	end
endmodule
